/* File: logic/radio_device.sv */
`default_nettype none
module radio_device #(
  parameter int MEM_DEPTH = 16,
  parameter int CYC_PER_US = radio_pkg::CLK_MHZ
) (
  input wire logic mclk,                        // system clock
  input wire logic rst_b,                       // async reset, active low
  radio_link_if.device link,                    // serial link
  input wire logic retain_en,                   // keep memory in sleep
  input wire logic xtal_ref,                    // crystal reference instead of module
  input wire logic high_rate,                   // high data rate timing
  input wire logic cal_fw_ok,                   // calibration firmware present
  input wire logic wake_timeout,                // wake-up timer pulse
  input wire logic cca_done,                    // assessment result pulse
  input wire logic cca_busy,                    // channel busy with cca_done
  input wire logic rx_eof,                      // receive end of frame pulse
  input wire logic tx_eof,                      // transmit end of frame pulse
  input wire logic auto_turn,                   // automatic turnaround enable
  input wire logic [7:0] temp_in,               // measured temperature
  output logic [5:0] radio_state,               // one-hot current state
  output logic busy,                            // transition in progress
  output logic ext_ref_en,                      // external reference enabled
  output logic rx_en,                           // receiver enabled
  output logic pa_ramp,                         // amplifier ramped up
  output logic osc_cal                          // oscillator calibration pulse
);
  import radio_pkg::*;

  localparam int AW = $clog2(MEM_DEPTH);

  generate
    if (MEM_DEPTH < 2 || MEM_DEPTH > 16 || (1 << AW) != MEM_DEPTH) begin : g_bad
      $error("MEM_DEPTH must be a power of two from 2 to 16");
    end
    if (CYC_PER_US < 1) begin : g_bad_rate
      $error("CYC_PER_US must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_p;
    logic cs_p;
    logic [2:0] bit_cnt;
    logic first_byte;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic wr_mode;
    logic rd_mode;
    logic [AW-1:0] addr;
    radio_state_t state;
    radio_state_t target;
    logic busy;
    logic [TW-1:0] timer;
    logic first_ready;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic miso;
    logic miso_oe;
    logic ext_ref_en;
    logic rx_en;
    logic pa_ramp;
    logic osc_cal;
  } dev_q_t;

  dev_q_t q, n;
  logic sclk_rise, sclk_fall, cs_fall, cs_act, byte_done;
  logic [7:0] rx_byte, status;
  logic hit;
  radio_state_t tgt;
  int us;

  assign sclk_rise = q.sclk_s[1] & ~q.sclk_p;
  assign sclk_fall = ~q.sclk_s[1] & q.sclk_p;
  assign cs_fall = ~q.cs_s[1] & q.cs_p;
  assign cs_act = ~q.cs_s[1];
  assign byte_done = cs_act & sclk_rise & (q.bit_cnt == 3'd7);
  assign rx_byte = {q.sh_in[6:0], q.mosi_s[1]};
  assign status = {q.busy, cal_fw_ok, q.state};

  // ---------------------------------------------------------------
  // transition selection for host commands and automatic events
  // ---------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    tgt = q.state;
    us = 0;
    if (!q.busy && byte_done && q.first_byte) begin
      case (q.state)
        CONFIG_IDLE_STATE: begin
          if (rx_byte == GO_SLEEP_CMD) begin
            hit = 1'b1; tgt = LOW_POWER_RETAIN_STATE; us = IDLE_SLEEP_US;
          end else if (rx_byte == GO_READY_CMD) begin
            hit = 1'b1; tgt = REFERENCE_READY_STATE;
            us = !q.first_ready ? READY_US : (xtal_ref ? FIRST_READY_XTAL_US : FIRST_READY_TCXO_US);
          end else if (rx_byte == CONFIGURE_DEVICE_CMD) begin
            hit = 1'b1; us = CONFIGURE_US;
          end
        end
        REFERENCE_READY_STATE: begin
          if (rx_byte == GO_SLEEP_CMD) begin
            hit = 1'b1; tgt = LOW_POWER_RETAIN_STATE; us = READY_SLEEP_US;
          end else if (rx_byte == GO_IDLE_CMD) begin
            hit = 1'b1; tgt = CONFIG_IDLE_STATE; us = READY_IDLE_US;
          end else if (rx_byte == SLOW_OSC_CALIBRATE_CMD && cal_fw_ok) begin
            hit = 1'b1; us = SLOW_OSC_CAL_US;
          end else if (rx_byte == RUN_CALIBRATION_CMD && cal_fw_ok) begin
            hit = 1'b1; us = DO_CAL_US;
          end else if (rx_byte == CHANNEL_ASSESS_CMD) begin
            hit = 1'b1; tgt = ASSESS_STATE; us = ASSESS_US;
          end else if (rx_byte == GO_TRANSMIT_CMD) begin
            hit = 1'b1; tgt = TRANSMIT_STATE; us = READY_TX_US;
          end else if (rx_byte == GO_RECEIVE_CMD) begin
            hit = 1'b1; tgt = RECEIVE_STATE; us = high_rate ? READY_RX_HI_US : READY_RX_LO_US;
          end
        end
        ASSESS_STATE: begin
          if (rx_byte == GO_READY_CMD) begin
            hit = 1'b1; tgt = REFERENCE_READY_STATE; us = ASSESS_READY_US;
          end else if (rx_byte == GO_TRANSMIT_CMD) begin
            hit = 1'b1; tgt = TRANSMIT_STATE; us = ASSESS_TX_US;
          end
        end
        TRANSMIT_STATE: begin
          if (rx_byte == GO_READY_CMD) begin
            hit = 1'b1; tgt = REFERENCE_READY_STATE; us = TX_READY_CMD_US;
          end else if (rx_byte == GO_TRANSMIT_CMD) begin
            hit = 1'b1; us = high_rate ? TX_TX_HI_US : TX_TX_LO_US;
          end else if (rx_byte == GO_RECEIVE_CMD) begin
            hit = 1'b1; tgt = RECEIVE_STATE; us = high_rate ? TX_RX_HI_US : TX_RX_LO_US;
          end
        end
        RECEIVE_STATE: begin
          if (rx_byte == GO_READY_CMD) begin
            hit = 1'b1; tgt = REFERENCE_READY_STATE; us = RX_READY_CMD_US;
          end else if (rx_byte == GO_RECEIVE_CMD) begin
            hit = 1'b1; us = high_rate ? RX_RX_HI_US : RX_RX_LO_US;
          end else if (rx_byte == GO_TRANSMIT_CMD) begin
            hit = 1'b1; tgt = TRANSMIT_STATE; us = RX_TX_CMD_US;
          end
        end
        default: hit = 1'b0;
      endcase
    end else if (!q.busy) begin
      // automatic events, only when no first command byte completes
      if (q.state == LOW_POWER_RETAIN_STATE && (wake_timeout || cs_fall)) begin
        hit = 1'b1; tgt = CONFIG_IDLE_STATE; us = WAKE_US;
      end else if (q.state == ASSESS_STATE && cca_done) begin
        hit = 1'b1;
        tgt = cca_busy ? REFERENCE_READY_STATE : TRANSMIT_STATE;
        us = cca_busy ? BUSY_READY_US : (high_rate ? CLEAR_TX_HI_US : CLEAR_TX_LO_US);
      end else if (q.state == TRANSMIT_STATE && tx_eof) begin
        hit = 1'b1;
        tgt = auto_turn ? RECEIVE_STATE : REFERENCE_READY_STATE;
        us = auto_turn ? (high_rate ? TX_RX_HI_US : TX_RX_LO_US) : TX_EOF_READY_US;
      end else if (q.state == RECEIVE_STATE && rx_eof) begin
        hit = 1'b1;
        tgt = auto_turn ? TRANSMIT_STATE : REFERENCE_READY_STATE;
        us = auto_turn ? RX_TX_TURN_US : RX_EOF_READY_US;
      end
    end
  end

  // ---------------------------------------------------------------
  // next state of all registers
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    n.sclk_s = {q.sclk_s[0], link.sclk};
    n.cs_s = {q.cs_s[0], link.cs_n};
    n.mosi_s = {q.mosi_s[0], link.mosi};
    n.sclk_p = q.sclk_s[1];
    n.cs_p = q.cs_s[1];
    n.osc_cal = 1'b0;
    // serial slave, mode 0, msb first
    if (cs_fall) begin
      n.bit_cnt = 3'd0;
      n.first_byte = 1'b1;
      n.wr_mode = 1'b0;
      n.rd_mode = 1'b0;
      n.miso = status[7];
      n.sh_out = {status[6:0], 1'b0};
    end else if (cs_act && sclk_rise) begin
      n.bit_cnt = q.bit_cnt + 3'd1;
      n.sh_in = rx_byte;
      if (byte_done) begin
        n.first_byte = 1'b0;
        n.sh_out = status;
        if (q.first_byte && q.state != LOW_POWER_RETAIN_STATE) begin
          n.addr = rx_byte[AW-1:0];
          n.wr_mode = rx_byte[7:4] == MEM_WRITE_OP;
          n.rd_mode = rx_byte[7:4] == MEM_READ_OP;
          if (rx_byte[7:4] == MEM_READ_OP) begin
            n.sh_out = q.mem[rx_byte[AW-1:0]];
          end
          if (rx_byte == TEMPERATURE_MONITOR_CMD && !q.busy) begin
            n.mem[TEMP_ADDR] = temp_in;
          end
        end else if (q.wr_mode) begin
          n.mem[q.addr] = rx_byte;
          n.addr = q.addr + 1'b1;
        end else if (q.rd_mode) begin
          n.addr = q.addr + 1'b1;
          n.sh_out = q.mem[AW'(q.addr + 1'b1)];
        end
      end
    end else if (cs_act && sclk_fall) begin
      n.miso = q.sh_out[7];
      n.sh_out = {q.sh_out[6:0], 1'b0};
    end
    n.miso_oe = cs_act;
    // transition timer
    if (q.busy) begin
      if (q.timer == '0) begin
        n.busy = 1'b0;
        n.state = q.target;
        if (q.target == LOW_POWER_RETAIN_STATE) begin
          n.first_ready = 1'b1;
          if (!retain_en) begin
            n.mem = '0;
          end
        end
      end else begin
        n.timer = q.timer - 1'b1;
      end
    end else if (hit) begin
      n.busy = 1'b1;
      n.target = tgt;
      n.timer = TW'(us * CYC_PER_US - 1);
      if (tgt == REFERENCE_READY_STATE && q.state == CONFIG_IDLE_STATE) begin
        n.first_ready = 1'b0;
      end
      if (byte_done && q.first_byte && (rx_byte == GO_RECEIVE_CMD || rx_byte == GO_TRANSMIT_CMD)) begin
        n.osc_cal = 1'b1;
      end
    end
    // reference stays on in every state above idle
    n.ext_ref_en = !(n.state inside {LOW_POWER_RETAIN_STATE, CONFIG_IDLE_STATE});
    n.rx_en = !n.busy && (n.state == RECEIVE_STATE || n.state == ASSESS_STATE);
    n.pa_ramp = !n.busy && n.state == TRANSMIT_STATE;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.sclk_s <= 2'b00;
      q.cs_s <= 2'b11;
      q.sclk_p <= 1'b0;
      q.cs_p <= 1'b1;
      q.state <= CONFIG_IDLE_STATE;
      q.target <= CONFIG_IDLE_STATE;
      q.first_ready <= 1'b1;
      q.miso <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign radio_state = q.state;
  assign busy = q.busy;
  assign ext_ref_en = q.ext_ref_en;
  assign rx_en = q.rx_en;
  assign pa_ramp = q.pa_ramp;
  assign osc_cal = q.osc_cal;
  assign link.miso = q.miso;
  assign link.miso_oe = q.miso_oe;
endmodule
`default_nettype wire

/* File: logic/radio_host.sv */
`default_nettype none
module radio_host #(
  parameter int HALF = radio_pkg::SCLK_HALF
) (
  input wire logic mclk,          // system clock
  input wire logic rst_b,         // async reset, active low
  radio_link_if.host link,        // serial link
  input wire logic req_valid,     // start a transaction
  output logic req_ready,         // ready for a transaction
  input wire logic req_two,       // send two bytes instead of one
  input wire logic [7:0] req_b0,  // first byte, command or opcode
  input wire logic [7:0] req_b1,  // second byte
  output logic rsp_valid,         // one-cycle pulse, answer ready
  output logic [7:0] rsp_b0,      // byte returned during first byte
  output logic [7:0] rsp_b1       // byte returned during second byte
);
  import radio_pkg::*;

  generate
    if (HALF < 8 || HALF > 255) begin : g_bad
      $error("HALF must be from 8 to 255");
    end
  endgenerate

  typedef enum logic [4:0] {
    H_IDLE = 5'b0_0001,
    H_LEAD = 5'b0_0010,
    H_SHIFT = 5'b0_0100,
    H_TAIL = 5'b0_1000,
    H_GAP = 5'b1_0000
  } host_st_t;

  typedef struct packed {
    host_st_t st;
    logic [1:0] miso_s;
    logic [8:0] div;
    logic [3:0] bits;
    logic two;
    logic [15:0] sh_out;
    logic [15:0] sh_in;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic ready;
    logic rsp_valid;
    logic [7:0] b0;
    logic [7:0] b1;
  } host_q_t;

  host_q_t q, n;

  // ---------------------------------------------------------------
  // serial master: drives the clock by dividing mclk
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    n.miso_s = {q.miso_s[0], link.miso_wire};
    n.rsp_valid = 1'b0;
    if (q.div != '0) begin
      n.div = q.div - 1'b1;
    end
    case (q.st)
      H_IDLE: begin
        if (req_valid) begin
          n.st = H_LEAD;
          n.cs_n = 1'b0;
          n.mosi = req_b0[7];
          n.sh_out = {req_b0[6:0], req_b1, 1'b0};
          n.two = req_two;
          n.bits = 4'd0;
          n.div = 9'(2 * HALF - 1);
        end
      end
      H_LEAD: begin
        if (q.div == '0) begin
          n.st = H_SHIFT;
          n.sclk = 1'b1;
          n.sh_in = {q.sh_in[14:0], q.miso_s[1]};
          n.div = 9'(HALF - 1);
        end
      end
      H_SHIFT: begin
        if (q.div == '0) begin
          n.div = 9'(HALF - 1);
          if (q.sclk) begin
            n.sclk = 1'b0;
            n.bits = q.bits + 4'd1;
            if (q.bits == (q.two ? 4'd15 : 4'd7)) begin
              n.st = H_TAIL;
            end else begin
              n.mosi = q.sh_out[15];
              n.sh_out = {q.sh_out[14:0], 1'b0};
            end
          end else begin
            n.sclk = 1'b1;
            n.sh_in = {q.sh_in[14:0], q.miso_s[1]};
          end
        end
      end
      H_TAIL: begin
        if (q.div == '0) begin
          n.st = H_GAP;
          n.cs_n = 1'b1;
          n.mosi = 1'b1;
          n.rsp_valid = 1'b1;
          n.b0 = q.two ? q.sh_in[15:8] : q.sh_in[7:0];
          n.b1 = q.two ? q.sh_in[7:0] : 8'h00FF;
          n.div = 9'(2 * HALF - 1);
        end
      end
      H_GAP: begin
        if (q.div == '0) begin
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
    n.ready = n.st == H_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= H_IDLE;
      q.miso_s <= 2'b11;
      q.cs_n <= 1'b1;
      q.mosi <= 1'b1;
      q.ready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign req_ready = q.ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_b0 = q.b0;
  assign rsp_b1 = q.b1;
  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.mosi = q.mosi;
endmodule
`default_nettype wire

/* File: logic/radio_link_if.sv */
`default_nettype none
interface radio_link_if;
  logic sclk;     // serial clock from host
  logic cs_n;     // chip select, active low
  logic mosi;     // host to device data
  logic miso;     // device data out
  logic miso_oe;  // device drives miso
  logic miso_wire;
  // idle line reads high when the device does not drive it
  assign miso_wire = miso_oe ? miso : 1'b1;
  modport host (output sclk, output cs_n, output mosi, input miso_wire);
  modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface
`default_nettype wire

/* File: logic/radio_pkg.sv */
// What this block does
// - host commands change state; device sequences itself
// - sleep state keeps memory only if retained
// - idle runs internal oscillator; host configures there
// - ready state enables external reference clock
// - timer timeout or select low wakes, 101us
// - sleep command: 95us from idle, 30us ready
// - ready command: 206/490us first, then 188us
// - configure command stays idle, 36us
// - idle command from ready takes 19us
// - slow osc cal, calibrations, temperature monitor
// - transmit command: amplifier ramp after 245us
// - receive command: receiver on 223/225us
// - assessment: busy back 16us, clear transmits 208/203us
// - transmit ends: frame end 26us, command 36us
// - transmit while transmitting retunes, 258/231us
// - transmit to receive by command/turnaround 204/208us
// - receive frame end 32us; ready command 46us
// - receive while receiving retunes, 216/220us
// - receive to transmit: turnaround 220, command 203
// - device is always serial slave
// - no-operation byte returns status byte
// - receive/transmit commands trigger oscillator calibration
`default_nettype none
package radio_pkg;
  localparam int CLK_MHZ = 40;
  localparam int TW = 24;
  localparam logic [7:0] NOP_CMD = 8'h00FF;
  localparam logic [7:0] GO_SLEEP_CMD = 8'h0081;
  localparam logic [7:0] GO_IDLE_CMD = 8'h0082;
  localparam logic [7:0] GO_READY_CMD = 8'h0083;
  localparam logic [7:0] GO_RECEIVE_CMD = 8'h0084;
  localparam logic [7:0] GO_TRANSMIT_CMD = 8'h0085;
  localparam logic [7:0] CONFIGURE_DEVICE_CMD = 8'h0086;
  localparam logic [7:0] CHANNEL_ASSESS_CMD = 8'h0087;
  localparam logic [7:0] RUN_CALIBRATION_CMD = 8'h0088;
  localparam logic [7:0] TEMPERATURE_MONITOR_CMD = 8'h0089;
  localparam logic [7:0] SLOW_OSC_CALIBRATE_CMD = 8'h008A;
  // memory access: high nibble is opcode, low bits are start address
  localparam logic [3:0] MEM_WRITE_OP = 4'h4;
  localparam logic [3:0] MEM_READ_OP = 4'h6;
  localparam int TEMP_ADDR = 0;
  // typical transition times in microseconds
  localparam int WAKE_US = 101;
  localparam int IDLE_SLEEP_US = 95;
  localparam int READY_SLEEP_US = 30;
  localparam int FIRST_READY_TCXO_US = 206;
  localparam int FIRST_READY_XTAL_US = 490;
  localparam int READY_US = 188;
  localparam int CONFIGURE_US = 36;
  localparam int READY_IDLE_US = 19;
  localparam int SLOW_OSC_CAL_US = 30000;
  localparam int DO_CAL_US = 1000;
  localparam int ASSESS_US = 230;
  localparam int READY_TX_US = 245;
  localparam int READY_RX_LO_US = 223;
  localparam int READY_RX_HI_US = 225;
  localparam int ASSESS_READY_US = 46;
  localparam int BUSY_READY_US = 16;
  localparam int CLEAR_TX_LO_US = 208;
  localparam int CLEAR_TX_HI_US = 203;
  localparam int ASSESS_TX_US = 239;
  localparam int TX_READY_CMD_US = 36;
  localparam int TX_EOF_READY_US = 26;
  localparam int TX_TX_LO_US = 258;
  localparam int TX_TX_HI_US = 231;
  localparam int TX_RX_LO_US = 204;
  localparam int TX_RX_HI_US = 208;
  localparam int RX_READY_CMD_US = 46;
  localparam int RX_EOF_READY_US = 32;
  localparam int RX_RX_LO_US = 216;
  localparam int RX_RX_HI_US = 220;
  localparam int RX_TX_TURN_US = 220;
  localparam int RX_TX_CMD_US = 203;
  // host serial clock half period in mclk cycles
  localparam int SCLK_HALF = 8;

  typedef enum logic [5:0] {
    LOW_POWER_RETAIN_STATE = 6'b00_0001,
    CONFIG_IDLE_STATE = 6'b00_0010,
    REFERENCE_READY_STATE = 6'b00_0100,
    RECEIVE_STATE = 6'b00_1000,
    TRANSMIT_STATE = 6'b01_0000,
    ASSESS_STATE = 6'b10_0000
  } radio_state_t;
endpackage
`default_nettype wire

/* File: tb/radio_checker_sva.sv */
`default_nettype none
module radio_checker_sva (
  input wire logic mclk,              // system clock
  input wire logic rst_b,             // async reset, active low
  input wire logic sclk,              // serial clock
  input wire logic cs_n,              // select, active low
  input wire logic mosi,              // host data
  input wire logic miso_oe,           // device drives miso
  input wire logic [5:0] radio_state, // one-hot state
  input wire logic busy,              // transition running
  input wire logic ext_ref_en,        // reference enabled
  input wire logic rx_en,             // receiver enabled
  input wire logic pa_ramp,           // amplifier ramped
  input wire logic osc_cal            // calibration pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // frame shape and state relations
  // ------------------------------------------------------------
  sequence lead_in;
    (!sclk && !cs_n)[*8] ##[7:9] $rose(sclk);
  endsequence
  sequence high_phase;
    sclk[*8] ##1 !sclk;
  endsequence
  a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("serial clock high outside a frame");
  a_frame_lead_in: assert property ($fell(cs_n) |-> lead_in) else $error("first clock edge misplaced");
  a_sclk_high_width: assert property ($rose(sclk) |-> high_phase) else $error("clock high phase width");
  a_mosi_stable_high: assert property ($rose(sclk) |-> $stable(mosi)[*8]) else $error("data moved while clock high");
  a_miso_released: assert property (cs_n[*6] |-> !miso_oe) else $error("miso driven while deselected");
  a_state_onehot: assert property ($onehot(radio_state)) else $error("state not one-hot");
  a_state_moves_done: assert property ($changed(radio_state) |-> $fell(busy)) else $error("state moved mid-transition");
  a_osc_cal_pulse: assert property (osc_cal |-> busy ##1 !osc_cal) else $error("calibration pulse wrong");
  a_ext_ref_state: assert property (!busy |-> ext_ref_en == (|radio_state[5:2])) else $error("reference enable wrong");
  a_rx_en_state: assert property (!busy |-> rx_en == (radio_state[3] || radio_state[5])) else $error("receiver enable wrong");
  a_pa_ramp_state: assert property (!busy |-> pa_ramp == radio_state[4]) else $error("amplifier enable wrong");
endmodule
`default_nettype wire

/* File: tb/radio_state_command_control_bench.sv */
`default_nettype none
module radio_state_command_control_bench import radio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid, req_two, retain_en, xtal_ref, high_rate, cal_fw_ok, auto_turn;
  logic wake_timeout, cca_done, cca_busy, rx_eof, tx_eof;
  logic [7:0] req_b0, req_b1, temp_in, rsp_b0, rsp_b1;
  logic req_ready, rsp_valid, busy, ext_ref_en, rx_en, pa_ramp, osc_cal;
  logic [5:0] radio_state;
  int failures = 0;
  int samples_checked = 0;
  int busy_total = 0;
  int cal_total = 0;

  radio_link_if u_radio_link_if ();
  radio_host u_radio_host (.mclk(mclk), .rst_b(rst_b), .link(u_radio_link_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_two(req_two), .req_b0(req_b0), .req_b1(req_b1), .rsp_valid(rsp_valid),
    .rsp_b0(rsp_b0), .rsp_b1(rsp_b1));
  radio_device #(.CYC_PER_US(1)) u_radio_device (.mclk(mclk), .rst_b(rst_b), .link(u_radio_link_if),
    .retain_en(retain_en), .xtal_ref(xtal_ref), .high_rate(high_rate), .cal_fw_ok(cal_fw_ok),
    .wake_timeout(wake_timeout), .cca_done(cca_done), .cca_busy(cca_busy), .rx_eof(rx_eof), .tx_eof(tx_eof),
    .auto_turn(auto_turn), .temp_in(temp_in), .radio_state(radio_state), .busy(busy), .ext_ref_en(ext_ref_en),
    .rx_en(rx_en), .pa_ramp(pa_ramp), .osc_cal(osc_cal));
  radio_checker_sva u_radio_checker_sva (.mclk(mclk), .rst_b(rst_b), .sclk(u_radio_link_if.sclk),
    .cs_n(u_radio_link_if.cs_n), .mosi(u_radio_link_if.mosi), .miso_oe(u_radio_link_if.miso_oe),
    .radio_state(radio_state), .busy(busy), .ext_ref_en(ext_ref_en), .rx_en(rx_en), .pa_ramp(pa_ramp),
    .osc_cal(osc_cal));

  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // busy cycles and calibration pulses, summed for timing checks
  always @(posedge mclk) begin
    busy_total <= busy_total + int'(busy === 1'b1);
    cal_total <= cal_total + int'(osc_cal === 1'b1);
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] b0, input logic two, input logic [7:0] b1);
    int n;
    n = 0;
    while (req_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_two <= two;
    req_b0 <= b0;
    req_b1 <= b1;
    @(posedge mclk);
    req_valid <= 1'b0;
    do begin
      @(negedge mclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    chk("answer wait", n < 2000, 1'b1);
  endtask
  task automatic settle(input int t0, input int k0, input int us, input int ncal, input logic [5:0] st);
    int n;
    n = 0;
    repeat (4) @(negedge mclk);
    while (busy !== 1'b0 && n < 40000) begin
      @(negedge mclk);
      n++;
    end
    chk("busy cycles", busy_total - t0, us);
    chk("cal pulses", cal_total - k0, ncal);
    chk("state", radio_state, st);
  endtask
  task automatic cmd(input logic [7:0] b0, input int us, input logic [5:0] st);
    int t0, k0;
    t0 = busy_total;
    k0 = cal_total;
    xfer(b0, 1'b0, 8'hFF);
    settle(t0, k0, us, int'(us != 0 && (b0 == GO_RECEIVE_CMD || b0 == GO_TRANSMIT_CMD)), st);
  endtask
  task automatic evt(input int which, input int us, input logic [5:0] st);
    int t0, k0;
    t0 = busy_total;
    k0 = cal_total;
    @(posedge mclk);
    case (which)
      0: wake_timeout <= 1'b1;
      1: cca_done <= 1'b1;
      2: rx_eof <= 1'b1;
      default: tx_eof <= 1'b1;
    endcase
    @(posedge mclk);
    {wake_timeout, cca_done, rx_eof, tx_eof} <= 4'h0;
    settle(t0, k0, us, 0, st);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    xfer({MEM_READ_OP, a}, 1'b1, 8'hFF);
    chk("memory", rsp_b1, exp);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic idle_cmds();
    xfer(NOP_CMD, 1'b0, 8'hFF);
    chk("status", rsp_b0, {2'b00, CONFIG_IDLE_STATE});
    cmd(CHANNEL_ASSESS_CMD, 0, CONFIG_IDLE_STATE);
    cmd(CONFIGURE_DEVICE_CMD, CONFIGURE_US, CONFIG_IDLE_STATE);
    cmd(TEMPERATURE_MONITOR_CMD, 0, CONFIG_IDLE_STATE);
    rd(4'h0, 8'h3C);
  endtask
  task automatic ready_cmds();
    cmd(GO_READY_CMD, FIRST_READY_TCXO_US, REFERENCE_READY_STATE);
    chk("ext ref", ext_ref_en, 1'b1);
    cmd(GO_IDLE_CMD, READY_IDLE_US, CONFIG_IDLE_STATE);
    chk("ext ref", ext_ref_en, 1'b0);
    cmd(GO_READY_CMD, READY_US, REFERENCE_READY_STATE);
  endtask
  task automatic cal_cmds();
    cmd(SLOW_OSC_CALIBRATE_CMD, 0, REFERENCE_READY_STATE);
    @(posedge mclk);
    cal_fw_ok <= 1'b1;
    cmd(RUN_CALIBRATION_CMD, DO_CAL_US, REFERENCE_READY_STATE);
    cmd(SLOW_OSC_CALIBRATE_CMD, SLOW_OSC_CAL_US, REFERENCE_READY_STATE);
    xfer(NOP_CMD, 1'b0, 8'hFF);
    chk("status", rsp_b0, {2'b01, REFERENCE_READY_STATE});
  endtask
  task automatic rx_tx_cmds();
    cmd(GO_RECEIVE_CMD, READY_RX_LO_US, RECEIVE_STATE);
    chk("receiver", rx_en, 1'b1);
    @(posedge mclk);
    high_rate <= 1'b1;
    cmd(GO_RECEIVE_CMD, RX_RX_HI_US, RECEIVE_STATE);
    evt(2, RX_EOF_READY_US, REFERENCE_READY_STATE);
    @(posedge mclk);
    high_rate <= 1'b0;
    cmd(GO_TRANSMIT_CMD, READY_TX_US, TRANSMIT_STATE);
    chk("amplifier", pa_ramp, 1'b1);
    cmd(GO_TRANSMIT_CMD, TX_TX_LO_US, TRANSMIT_STATE);
    evt(3, TX_EOF_READY_US, REFERENCE_READY_STATE);
  endtask
  task automatic cca_cmds();
    @(posedge mclk);
    cca_busy <= 1'b1;
    cmd(CHANNEL_ASSESS_CMD, ASSESS_US, ASSESS_STATE);
    chk("receiver", rx_en, 1'b1);
    evt(1, BUSY_READY_US, REFERENCE_READY_STATE);
    @(posedge mclk);
    cca_busy <= 1'b0;
    cmd(CHANNEL_ASSESS_CMD, ASSESS_US, ASSESS_STATE);
    evt(1, CLEAR_TX_LO_US, TRANSMIT_STATE);
  endtask
  task automatic turn_cmds();
    cmd(GO_RECEIVE_CMD, TX_RX_LO_US, RECEIVE_STATE);
    cmd(GO_TRANSMIT_CMD, RX_TX_CMD_US, TRANSMIT_STATE);
    cmd(GO_READY_CMD, TX_READY_CMD_US, REFERENCE_READY_STATE);
    cmd(GO_RECEIVE_CMD, READY_RX_LO_US, RECEIVE_STATE);
    cmd(GO_READY_CMD, RX_READY_CMD_US, REFERENCE_READY_STATE);
    cmd(GO_TRANSMIT_CMD, READY_TX_US, TRANSMIT_STATE);
    @(posedge mclk);
    auto_turn <= 1'b1;
    evt(3, TX_RX_LO_US, RECEIVE_STATE);
    evt(2, RX_TX_TURN_US, TRANSMIT_STATE);
    @(posedge mclk);
    auto_turn <= 1'b0;
    cmd(GO_READY_CMD, TX_READY_CMD_US, REFERENCE_READY_STATE);
  endtask
  task automatic sleep_cmds();
    xfer({MEM_WRITE_OP, 4'h1}, 1'b1, 8'h5A);
    @(posedge mclk);
    retain_en <= 1'b1;
    cmd(GO_SLEEP_CMD, READY_SLEEP_US, LOW_POWER_RETAIN_STATE);
    evt(0, WAKE_US, CONFIG_IDLE_STATE);
    rd(4'h1, 8'h5A);
    @(posedge mclk);
    retain_en <= 1'b0;
    cmd(GO_SLEEP_CMD, IDLE_SLEEP_US, LOW_POWER_RETAIN_STATE);
    cmd(NOP_CMD, WAKE_US, CONFIG_IDLE_STATE);
    rd(4'h1, 8'h00);
    @(posedge mclk);
    xtal_ref <= 1'b1;
    cmd(GO_READY_CMD, FIRST_READY_XTAL_US, REFERENCE_READY_STATE);
  endtask

  initial begin
    {req_valid, req_two, retain_en, xtal_ref, high_rate, cal_fw_ok, auto_turn} = 7'h00;
    {wake_timeout, cca_done, cca_busy, rx_eof, tx_eof} = 5'h00;
    req_b0 = 8'h00;
    req_b1 = 8'h00;
    temp_in = 8'h3C;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    idle_cmds();
    ready_cmds();
    cal_cmds();
    rx_tx_cmds();
    cca_cmds();
    turn_cmds();
    sleep_cmds();
    print_verdict();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
